// ### rtl/kdi_top.v
// Keyboard and display interface: key and uplink capture, mark capture,
// verb and noun entry, display state table and relay word output.
// Assumes one 10 MHz clock; keyboard, uplink and switch pins are async.
//
// Behaviour
// - Key code lands in key word bits 1-5.
// - Every key press raises key interrupt four.
// - Uplink word raises interrupt five, same codes.
// - Decoder treats keyboard and uplink alike.
// - Blocked uplink switch drops uplink characters.
// - Mark sets bit 15, interrupt, capture strobe.
// - Panel of 24 sections, signs and digits.
// - Relay word: right, left, special, pair select.
// - Output step on every second 60 ms tick.
// - Eleven-entry table mirrors the panel state.
// - Output only pairs whose content changed.
// - Verb and noun are two octal digits.
// - Verb key blanks verb digits, clears code.
// - Noun key blanks noun digits, clears code.
// - Enter executes displayed codes, any order.
// - Nothing executes before enter is pressed.
// - Rekeying one code leaves the other alone.
// - Key service fetches code, posts decoder request.
// - Digits beyond two are ignored.
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`include "kdi_map.vh"

module kdi_top
#(
  parameter TICK_CYCLES = (`KDI_TICK_MS * `KDI_CLK_KHZ),
  parameter NPAIRS = 11
)
(
  // Clock and reset.
  input wire clk_in,
  input wire rstn_in,
  // Keyboard and uplink pins.
  input wire [4:0] key_code_in,
  input wire key_strobe_in,
  input wire mark_in,
  input wire [4:0] uplink_code_in,
  input wire uplink_strobe_in,
  input wire uplink_block_in,
  // Register port.
  input wire [3:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [15:0] reg_rdata_out,
  // Interrupt and event outputs.
  output reg key_interrupt_out,
  output reg uplink_interrupt_out,
  output reg mark_capture_out,
  output reg execute_out,
  output reg [5:0] exec_verb_out,
  output reg [5:0] exec_noun_out,
  // Relay output word to the panel.
  output reg [14:0] relay_output_word_out,
  output reg relay_strobe_out
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------

  // Two-stage release of the asynchronous reset.
  reg rst_s1;
  reg rstn;

  // Reset is applied at once and released on clock edges.
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_s1 <= 1'b0;
      rstn <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rstn <= rst_s1;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------

  // Pin vector: key code, key strobe, mark, uplink code, strobe, block.
  // Bits: key code 13:9, key strobe 8, mark 7, uplink code 6:2, strobe 1, block 0.
  wire [13:0] pins_raw = {key_code_in, key_strobe_in, mark_in, uplink_code_in,
    uplink_strobe_in, uplink_block_in};
  reg [13:0] pins_s1;
  reg [13:0] pins_s2;
  reg [2:0] strobe_prev;

  // Two flops on every pin; edge detection only looks at the second.
  always @(posedge clk_in or negedge rstn)
  begin
    if (!rstn)
    begin
      pins_s1 <= 14'h0000;
      pins_s2 <= 14'h0000;
      strobe_prev <= 3'h0;
    end
    else
    begin
      pins_s1 <= pins_raw;
      pins_s2 <= pins_s1;
      strobe_prev <= {pins_s2[8], pins_s2[7], pins_s2[1]};
    end
  end

  // Rising edges of the strobes. Codes are assumed stable by then.
  wire key_evt = pins_s2[8] & ~strobe_prev[2];
  wire mark_evt = pins_s2[7] & ~strobe_prev[1];
  wire up_evt = pins_s2[1] & ~strobe_prev[0];
  wire up_blocked = pins_s2[0];

  // ----------------------------------------------------------------
  // Key input word and pending character
  // ----------------------------------------------------------------

  reg [14:0] key_input_word; // Low five bits code, top bit mark.
  reg pend; // A character waits for the decoder.
  reg [4:0] pend_code; // The waiting character.
  reg [4:0] verb_key; // Loadable key code assignments.
  reg [4:0] noun_key;
  reg [4:0] enter_key;

  // Register port decode, shared by several processes.
  wire wr_ctrl = reg_wr_in & (reg_addr_in == `KDI_REG_CTRL);
  wire wr_pair = reg_wr_in & (reg_addr_in == `KDI_REG_PAIR_WRITE);
  wire wr_map = reg_wr_in & (reg_addr_in == `KDI_REG_KEYMAP);
  wire wr_ack = reg_wr_in & (reg_addr_in == `KDI_REG_REQ_ACK);

  // A character accepted from either source this cycle.
  wire up_ok = up_evt & ~up_blocked;
  wire char_evt = key_evt | up_ok;
  wire [4:0] char_code = key_evt ? pins_s2[13:9] : pins_s2[6:2];

  // The decoder consumes the pending character one cycle after it appears.
  wire consume = pend;

  // Key word load, interrupts and the pending flag.
  always @(posedge clk_in or negedge rstn)
  begin
    if (!rstn)
    begin
      key_input_word <= 15'h0000;
      pend <= 1'b0;
      pend_code <= 5'h00;
      key_interrupt_out <= 1'b0;
      uplink_interrupt_out <= 1'b0;
      mark_capture_out <= 1'b0;
      verb_key <= `KDI_DEF_VERB_CODE;
      noun_key <= `KDI_DEF_NOUN_CODE;
      enter_key <= `KDI_DEF_ENTER_CODE;
    end
    else
    begin
      key_interrupt_out <= key_evt | mark_evt;
      uplink_interrupt_out <= up_ok;
      mark_capture_out <= mark_evt;
      if (key_evt)
      begin
        key_input_word[4:0] <= pins_s2[13:9];
      end
      if (mark_evt)
      begin
        key_input_word[`KDI_KEY_MARK_BIT] <= 1'b1;
      end
      else if (wr_ack && reg_wdata_in[1])
      begin
        key_input_word[`KDI_KEY_MARK_BIT] <= 1'b0;
      end
      // A new character wins over the consume of the previous one.
      if (char_evt)
      begin
        pend <= 1'b1;
        pend_code <= char_code;
      end
      else if (consume)
      begin
        pend <= 1'b0;
      end
      if (wr_map)
      begin
        verb_key <= reg_wdata_in[4:0];
        noun_key <= reg_wdata_in[9:5];
        enter_key <= reg_wdata_in[14:10];
      end
    end
  end

  // ----------------------------------------------------------------
  // Character decoder
  // ----------------------------------------------------------------

  // Classify a key code against the loadable map; used twice below.
  function [2:0] kdi_classify;
    input [4:0] code;
    input [4:0] vk;
    input [4:0] nk;
    input [4:0] ek;
    begin
      if (code == vk)
        kdi_classify = `KDI_CLS_VERB;
      else if (code == nk)
        kdi_classify = `KDI_CLS_NOUN;
      else if (code == ek)
        kdi_classify = `KDI_CLS_ENTER;
      else if (code[4:3] == 2'b00)
        kdi_classify = `KDI_CLS_DIGIT; // Octal digits 0-7 only.
      else
        kdi_classify = `KDI_CLS_OTHER;
    end
  endfunction

  wire [2:0] cls = kdi_classify(pend_code, verb_key, noun_key, enter_key);
  wire [2:0] map_cls = kdi_classify(reg_wdata_in[4:0], verb_key, noun_key, enter_key);

  reg [5:0] verb_code; // Two octal digits.
  reg [5:0] noun_code;
  reg [1:0] verb_cnt; // Digits taken so far.
  reg [1:0] noun_cnt;
  reg target_noun; // Digits go to the noun when set.
  reg entry_open; // A verb or noun key opened digit entry.

  // Relay codes for digits 0-9, loadable per digit.
  reg [4:0] relay_lut [0:9];

  // Verb and noun entry; digits also drive the panel pair contents.
  always @(posedge clk_in or negedge rstn)
  begin
    if (!rstn)
    begin
      verb_code <= 6'h00;
      noun_code <= 6'h00;
      verb_cnt <= 2'h0;
      noun_cnt <= 2'h0;
      target_noun <= 1'b0;
      entry_open <= 1'b0;
      execute_out <= 1'b0;
      exec_verb_out <= 6'h00;
      exec_noun_out <= 6'h00;
    end
    else
    begin
      execute_out <= 1'b0;
      if (consume)
      begin
        case (cls)
          `KDI_CLS_VERB:
          begin
            verb_code <= 6'h00;
            verb_cnt <= 2'h0;
            target_noun <= 1'b0;
            entry_open <= 1'b1;
          end
          `KDI_CLS_NOUN:
          begin
            noun_code <= 6'h00;
            noun_cnt <= 2'h0;
            target_noun <= 1'b1;
            entry_open <= 1'b1;
          end
          `KDI_CLS_DIGIT:
          begin
            if (entry_open && !target_noun && verb_cnt != 2'h2)
            begin
              verb_code <= {verb_code[2:0], pend_code[2:0]};
              verb_cnt <= verb_cnt + 2'h1;
            end
            else if (entry_open && target_noun && noun_cnt != 2'h2)
            begin
              noun_code <= {noun_code[2:0], pend_code[2:0]};
              noun_cnt <= noun_cnt + 2'h1;
            end
          end
          `KDI_CLS_ENTER:
          begin
            execute_out <= 1'b1;
            exec_verb_out <= verb_code;
            exec_noun_out <= noun_code;
            entry_open <= 1'b0;
          end
          default:
          begin
            entry_open <= entry_open;
          end
        endcase
      end
    end
  end

  // Display content for a code digit: blank until keyed.
  function [4:0] kdi_digit;
    input [1:0] cnt;
    input need;
    input [2:0] val;
    input [4:0] r0, r1, r2, r3, r4, r5, r6, r7;
    begin
      if (cnt < {1'b0, need} + 2'h1)
        kdi_digit = `KDI_RELAY_BLANK;
      else
        case (val)
          3'h0: kdi_digit = r0;
          3'h1: kdi_digit = r1;
          3'h2: kdi_digit = r2;
          3'h3: kdi_digit = r3;
          3'h4: kdi_digit = r4;
          3'h5: kdi_digit = r5;
          3'h6: kdi_digit = r6;
          default: kdi_digit = r7;
        endcase
    end
  endfunction

  // Left digit shows once one is keyed, right digit after two.
  wire [4:0] verb_l = kdi_digit(verb_cnt, 1'b0, verb_cnt == 2'h1 ? verb_code[2:0] :
    verb_code[5:3], relay_lut[0], relay_lut[1], relay_lut[2], relay_lut[3],
    relay_lut[4], relay_lut[5], relay_lut[6], relay_lut[7]);
  wire [4:0] verb_r = kdi_digit(verb_cnt, 1'b1, verb_code[2:0], relay_lut[0],
    relay_lut[1], relay_lut[2], relay_lut[3], relay_lut[4], relay_lut[5],
    relay_lut[6], relay_lut[7]);
  wire [4:0] noun_l = kdi_digit(noun_cnt, 1'b0, noun_cnt == 2'h1 ? noun_code[2:0] :
    noun_code[5:3], relay_lut[0], relay_lut[1], relay_lut[2], relay_lut[3],
    relay_lut[4], relay_lut[5], relay_lut[6], relay_lut[7]);
  wire [4:0] noun_r = kdi_digit(noun_cnt, 1'b1, noun_code[2:0], relay_lut[0],
    relay_lut[1], relay_lut[2], relay_lut[3], relay_lut[4], relay_lut[5],
    relay_lut[6], relay_lut[7]);

  // ----------------------------------------------------------------
  // Display state table and output step
  // ----------------------------------------------------------------

  // Wanted content per pair (special bit, left, right) and what the panel shows.
  reg [10:0] want [0:NPAIRS-1];
  reg [10:0] shown [0:NPAIRS-1];
  reg [22:0] tick_cnt;
  reg tick_half; // Toggles every tick; output runs on every second one.
  reg [3:0] scan;
  wire tick = (tick_cnt == TICK_CYCLES - 1);
  wire step = tick & tick_half;

  // Find the lowest-numbered changed pair; the scan point is not used.
  reg [3:0] hit;
  reg found;
  integer i;
  always @*
  begin
    hit = 4'h0;
    found = 1'b0;
    for (i = NPAIRS - 1; i >= 0; i = i - 1)
    begin
      if (want[i] != shown[i])
      begin
        hit = i[3:0];
        found = 1'b1;
      end
    end
  end

  // Tick divider, table updates and relay word issue.
  integer k;
  always @(posedge clk_in or negedge rstn)
  begin
    if (!rstn)
    begin
      tick_cnt <= 23'h00_0000;
      tick_half <= 1'b0;
      scan <= 4'h0;
      relay_output_word_out <= 15'h0000;
      relay_strobe_out <= 1'b0;
      for (k = 0; k < NPAIRS; k = k + 1)
      begin
        want[k] <= 11'h000;
        shown[k] <= 11'h7FF; // Unknown panel: force a full refresh.
      end
      for (k = 0; k < 10; k = k + 1)
        relay_lut[k] <= k[4:0] + 5'h01;
    end
    else
    begin
      relay_strobe_out <= 1'b0;
      tick_cnt <= tick ? 23'h00_0000 : tick_cnt + 23'h00_0001;
      if (tick)
        tick_half <= ~tick_half;
      if (wr_pair && reg_wdata_in[15:12] < NPAIRS)
        want[reg_wdata_in[15:12]] <= reg_wdata_in[10:0];
      if (wr_ctrl && reg_wdata_in[15:12] < 4'hA)
        relay_lut[reg_wdata_in[15:12]] <= reg_wdata_in[4:0];
      want[`KDI_SLOT_VERB] <= {1'b0, verb_l, verb_r};
      want[`KDI_SLOT_NOUN] <= {1'b0, noun_l, noun_r};
      if (step && found)
      begin
        // Right bits 1-5, left 6-10, special 11, pair select 12-15.
        relay_output_word_out <= {hit + 4'h1, want[hit]};
        relay_strobe_out <= 1'b1;
        shown[hit] <= want[hit];
        scan <= hit;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------

  // Read data stands in the cycle after the read strobe; unmapped reads zero.
  always @(posedge clk_in or negedge rstn)
  begin
    if (!rstn)
      reg_rdata_out <= 16'h0000;
    else if (reg_rd_in)
      case (reg_addr_in)
        `KDI_REG_KEY_WORD: reg_rdata_out <= {1'b0, key_input_word};
        `KDI_REG_RELAY_WORD: reg_rdata_out <= {1'b0, relay_output_word_out};
        `KDI_REG_CODES: reg_rdata_out <= {4'h0, noun_code, verb_code};
        `KDI_REG_STATUS: reg_rdata_out <= {8'h00, map_cls, scan, pend};
        `KDI_REG_KEYMAP: reg_rdata_out <= {1'b0, enter_key, noun_key, verb_key};
        default: reg_rdata_out <= 16'h0000;
      endcase
    else
      reg_rdata_out <= 16'h0000;
  end

endmodule

// ### rtl/kdi_map.vh
// Constants for the keyboard and display interface block.
// Included by the design file and the testbench; holds definitions only.
`ifndef KDI_MAP_VH
`define KDI_MAP_VH
// Register offsets on the plain register port.
`define KDI_REG_KEY_WORD 4'h0
`define KDI_REG_RELAY_WORD 4'h1
`define KDI_REG_CODES 4'h2
`define KDI_REG_STATUS 4'h3
`define KDI_REG_PAIR_WRITE 4'h4
`define KDI_REG_CTRL 4'h5
`define KDI_REG_KEYMAP 4'h6
`define KDI_REG_REQ_ACK 4'h7
// Key input word fields.
`define KDI_KEY_MARK_BIT 14
// Relay output word fields.
`define KDI_RELAY_SPECIAL_BIT 10
`define KDI_RELAY_SEL_LSB 11
// Character class codes returned by the key lookup.
`define KDI_CLS_DIGIT 3'h0
`define KDI_CLS_VERB 3'h1
`define KDI_CLS_NOUN 3'h2
`define KDI_CLS_ENTER 3'h3
`define KDI_CLS_OTHER 3'h4
// Default key codes (loadable through the key map register).
`define KDI_DEF_VERB_CODE 5'h11
`define KDI_DEF_NOUN_CODE 5'h1F
`define KDI_DEF_ENTER_CODE 5'h1C
// Relay code for a blank character.
`define KDI_RELAY_BLANK 5'h00
// Table slots that hold the verb and noun digit pairs.
`define KDI_SLOT_VERB 4'h1
`define KDI_SLOT_NOUN 4'h2
// Tick timing: 60 ms period at a 10 MHz clock.
`define KDI_TICK_MS 60
`define KDI_CLK_KHZ 10000
`endif

// ### sim/kdi_panel_model.sv
// Relay panel model: each character pair keeps its relays until reselected.
// Assumes the pair select sits in the top four bits of the relay word.
`timescale 1ns/10ps
module kdi_panel_model
(
  // Clock and relay word from the block.
  input wire clk_in,
  input wire [14:0] relay_word_in,
  input wire relay_strobe_in,
  // Inspection port for the bench.
  input wire [3:0] look_in,
  output wire [10:0] look_out
);
  // Latched pair contents; all relays start set so a refresh shows.
  reg [10:0] shown [0:15];
  integer i;
  initial
  begin
    for (i = 0; i < 16; i = i + 1)
      shown[i] = 11'h7ff;
  end
  // Latch the word into the selected pair on each strobe.
  always @(posedge clk_in)
  begin
    if (relay_strobe_in)
      shown[relay_word_in[14:11]] <= relay_word_in[10:0];
  end
  assign look_out = shown[look_in];
endmodule

// ### sim/kdi_props.sv
// Checker for the keyboard and display block, bound to its top ports.
// Assumes one clock and the asynchronous active-low reset.
`timescale 1ns/10ps
module kdi_props
#(
  parameter TICK_CYCLES = 20
)
(
  input wire clk_in,
  input wire rstn_in,
  input wire key_strobe_in,
  input wire mark_in,
  input wire uplink_strobe_in,
  input wire uplink_block_in,
  input wire key_interrupt_out,
  input wire uplink_interrupt_out,
  input wire mark_capture_out,
  input wire execute_out,
  input wire [5:0] exec_verb_out,
  input wire [5:0] exec_noun_out,
  input wire [14:0] relay_output_word_out,
  input wire relay_strobe_out
);
  // Cycles since the last relay word; steps must fall on tick pairs.
  int gap;
  logic seen;
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      gap <= 0;
      seen <= 1'b0;
    end
    else if (relay_strobe_out)
    begin
      gap <= 1;
      seen <= 1'b1;
    end
    else
      gap <= gap + 1;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  sequence key_rise;
    $rose(key_strobe_in);
  endsequence
  sequence up_open;
    $rose(uplink_strobe_in) && !uplink_block_in && !$past(uplink_block_in, 4);
  endsequence
  key_irq_a: assert property (key_rise |-> ##[2:5] key_interrupt_out)
    else $error("key press gave no interrupt");
  irq_pulse_a: assert property (key_interrupt_out |=> !key_interrupt_out)
    else $error("key interrupt longer than one cycle");
  up_irq_a: assert property (up_open |-> ##[2:5] uplink_interrupt_out)
    else $error("uplink word gave no interrupt");
  up_block_a: assert property ($rose(uplink_strobe_in) && uplink_block_in
    && $past(uplink_block_in, 4) |-> !uplink_interrupt_out [*6])
    else $error("blocked uplink raised an interrupt");
  mark_cap_a: assert property ($rose(mark_in) |-> ##[2:5] mark_capture_out)
    else $error("mark gave no capture");
  step_gap_a: assert property (relay_strobe_out && seen
    |-> (gap % (2 * TICK_CYCLES)) == 0)
    else $error("relay word off the second tick");
  word_hold_a: assert property (!relay_strobe_out |-> $stable(relay_output_word_out))
    else $error("relay word changed without strobe");
  pair_sel_a: assert property (relay_strobe_out
    |-> relay_output_word_out[14:11] inside {[1:11]})
    else $error("relay pair select out of range");
  exec_hold_a: assert property (!execute_out
    |-> $stable(exec_verb_out) && $stable(exec_noun_out))
    else $error("codes changed without enter");
endmodule
bind kdi_top kdi_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .clk_in(clk_in),
  .rstn_in(rstn_in),
  .key_strobe_in(key_strobe_in),
  .mark_in(mark_in),
  .uplink_strobe_in(uplink_strobe_in),
  .uplink_block_in(uplink_block_in),
  .key_interrupt_out(key_interrupt_out),
  .uplink_interrupt_out(uplink_interrupt_out),
  .mark_capture_out(mark_capture_out),
  .execute_out(execute_out),
  .exec_verb_out(exec_verb_out),
  .exec_noun_out(exec_noun_out),
  .relay_output_word_out(relay_output_word_out),
  .relay_strobe_out(relay_strobe_out)
);

// ### sim/keyboard_display_interface_tb.sv
// Testbench: key, uplink, mark, verb and noun entry, relay output.
// Assumes the block, the panel model and the bound checker.
`timescale 1ns/10ps
`include "kdi_map.vh"
module keyboard_display_interface_tb;
  reg clk_in;
  reg rstn_in = 1'b0;
  reg [4:0] kc = 5'h00;
  reg ks = 1'b0;
  reg mk = 1'b0;
  reg us = 1'b0;
  reg ub = 1'b0;
  reg [3:0] ra = 4'h0;
  reg [15:0] wd = 16'h0000;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [3:0] look = 4'h4;
  wire [15:0] rdat;
  wire kirq, uirq, mcap, exe, rstb;
  wire [5:0] ev, en;
  wire [14:0] rword;
  wire [10:0] pane;
  integer n_fail = 0;
  integer cmp_count = 0;
  integer n_exec = 0;
  integer i, k;
  reg [15:0] v;
  reg got;
  // Command keys: verb, 1, 2, a third digit that must be dropped, noun, 3, 4.
  reg [4:0] cmd [0:6] = '{`KDI_DEF_VERB_CODE, 5'h01, 5'h02, 5'h07,
    `KDI_DEF_NOUN_CODE, 5'h03, 5'h04};
  kdi_top #(.TICK_CYCLES(20)) DUT (.clk_in(clk_in), .rstn_in(rstn_in),
    .key_code_in(kc), .key_strobe_in(ks), .mark_in(mk), .uplink_code_in(kc),
    .uplink_strobe_in(us), .uplink_block_in(ub), .reg_addr_in(ra),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
    .key_interrupt_out(kirq), .uplink_interrupt_out(uirq),
    .mark_capture_out(mcap), .execute_out(exe), .exec_verb_out(ev),
    .exec_noun_out(en), .relay_output_word_out(rword), .relay_strobe_out(rstb));
  kdi_panel_model u_panel (.clk_in(clk_in), .relay_word_in(rword),
    .relay_strobe_in(rstb), .look_in(look), .look_out(pane));
  // 10 MHz clock.
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // Count enter executions as they happen.
  always @(posedge clk_in)
  begin
    if (exe === 1'b1)
      n_exec <= n_exec + 1;
  end
  task chk(input string nm, input [15:0] e, input [15:0] g);
    cmp_count = cmp_count + 1;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_fail = n_fail + 1;
    end
  endtask
  task wreg(input [3:0] a, input [15:0] d);
    @(posedge clk_in);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task rreg(input [3:0] a, input [15:0] e, input string nm);
    @(posedge clk_in);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    chk(nm, e, rdat);
  endtask
  // One key or uplink word; the code settles a cycle before its strobe.
  task press(input up, input [4:0] c, input exp);
    got = 1'b0;
    @(posedge clk_in);
    kc <= c;
    @(posedge clk_in);
    if (up)
      us <= 1'b1;
    else
      ks <= 1'b1;
    for (k = 0; k < 8; k = k + 1)
    begin
      @(posedge clk_in);
      #1 got = got | ((up ? uirq : kirq) === 1'b1);
    end
    @(posedge clk_in);
    us <= 1'b0;
    ks <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk("interrupt", {15'h0000, exp}, {15'h0000, got});
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog: a hang counts as a mismatch.
  initial
  begin
    repeat (20000) @(posedge clk_in);
    n_fail = n_fail + 1;
    finish_test;
  end
  initial
  begin
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rreg(4'h0, 16'h0000, "key word");
    rreg(4'hF, 16'h0000, "unmapped");
    rreg(4'h6, 16'h73F1, "key map");
    press(1'b0, 5'h05, 1'b1);
    rreg(4'h0, 16'h0005, "key word");
    $display("test key done");
    for (i = 0; i < 7; i = i + 1)
      press(1'b0, cmd[i], 1'b1);
    chk("exec count", 16'h0000, n_exec[15:0]);
    rreg(4'h2, 16'h070A, "codes");
    press(1'b0, `KDI_DEF_ENTER_CODE, 1'b1);
    chk("exec count", 16'h0001, n_exec[15:0]);
    chk("verb", 16'h000A, {10'h000, ev});
    chk("noun", 16'h001C, {10'h000, en});
    $display("test command done");
    press(1'b1, `KDI_DEF_NOUN_CODE, 1'b1);
    press(1'b1, 5'h05, 1'b1);
    press(1'b1, 5'h06, 1'b1);
    press(1'b1, `KDI_DEF_ENTER_CODE, 1'b1);
    chk("verb", 16'h000A, {10'h000, ev});
    chk("noun", 16'h002E, {10'h000, en});
    ub <= 1'b1;
    repeat (5) @(posedge clk_in);
    press(1'b1, `KDI_DEF_VERB_CODE, 1'b0);
    rreg(4'h2, 16'h0B8A, "codes");
    @(posedge clk_in);
    ub <= 1'b0;
    press(1'b0, `KDI_DEF_VERB_CODE, 1'b1);
    rreg(4'h2, 16'h0B80, "codes");
    press(1'b0, `KDI_DEF_NOUN_CODE, 1'b1);
    rreg(4'h2, 16'h0000, "codes");
    $display("test entry done");
    @(posedge clk_in);
    mk <= 1'b1;
    got = 1'b0;
    for (k = 0; k < 8; k = k + 1)
    begin
      @(posedge clk_in);
      #1 got = got | (mcap === 1'b1);
    end
    @(posedge clk_in);
    mk <= 1'b0;
    chk("mark capture", 16'h0001, {15'h0000, got});
    rreg(4'h0, 16'h401F, "mark bit");
    wreg(4'h7, 16'h0002);
    rreg(4'h0, 16'h001F, "mark bit");
    $display("test mark done");
    wreg(4'h4, {4'h3, 1'b0, 11'h155});
    wreg(4'h4, {4'hB, 1'b0, 11'h2AA});
    got = 1'b0;
    for (k = 0; k < 1500 && !got; k = k + 1)
    begin
      @(posedge clk_in);
      #1 got = (rstb === 1'b1) && (rword[14:11] === 4'h4);
    end
    chk("pair issued", 16'h0001, {15'h0000, got});
    chk("relay word", {1'b0, 4'h4, 11'h155}, {1'b0, rword});
    repeat (700) @(posedge clk_in);
    @(posedge clk_in);
    #1;
    chk("panel pair", 16'h0155, {5'h00, pane});
    v = 16'h0000;
    for (k = 0; k < 200; k = k + 1)
    begin
      @(posedge clk_in);
      #1 v = v + {15'h0000, rstb === 1'b1};
    end
    chk("idle strobes", 16'h0000, v);
    $display("test display done");
    finish_test;
  end
endmodule
